// >>> pcrs_core.sv
// program counter, pc latches and hardware return stack
// assumes sequencer commands on clk; avalon-mm slave answers one cycle after request
`timescale 1ns/10ps
`default_nettype none
module pcrs_core (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire pcrs_pkg::pcrs_cmd_s cmd,
   input  wire logic [5:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   output logic [20:0]             pc,
   output logic                    overflow_reset
);
   pcrs_pkg::pcrs_state_s st;
   pcrs_pkg::pcrs_state_s next_st;

   logic [3:0]  word;
   logic        mapped;
   logic [4:0]  idx;
   logic [20:0] top_of_stack;
   logic        req;
   logic [20:0] push_val;
   logic        do_push;

   assign word = avs_address[5:2];
   // taken only while idle; the held request is ignored in the answer cycle
   assign req  = (avs_read | avs_write) & ~st.wait_n;
   assign idx  = st.sp - 5'h01;
   assign top_of_stack  = (st.sp == pcrs_pkg::SP_RST) ? pcrs_pkg::PC_RST : st.stk[idx];

   always_comb begin
      next_st = st;
      next_st.wait_n = 1'b0;
      next_st.core_reset = 1'b0;
      mapped = (word <= pcrs_pkg::OFS_CFG);
      push_val = pcrs_pkg::PC_RST;
      do_push = 1'b0;

      // sequencer side
      if (cmd.valid) begin
         case (cmd.op)
            pcrs_pkg::PCRS_OP_STEP: begin
               next_st.pc = st.pc + pcrs_pkg::PC_STEP;
            end
            pcrs_pkg::PCRS_OP_JUMP: begin
               next_st.pc = {cmd.target[20:1], 1'b0};
            end
            pcrs_pkg::PCRS_OP_CALL: begin
               // pc already points past the call; latches untouched
               do_push = 1'b1;
               push_val = st.pc;
               next_st.pc = {cmd.target[20:1], 1'b0};
            end
            pcrs_pkg::PCRS_OP_PUSH: begin
               do_push = 1'b1;
               push_val = st.pc;
               next_st.pc = st.pc + pcrs_pkg::PC_STEP;
            end
            pcrs_pkg::PCRS_OP_RETURN: begin
               if (st.sp == pcrs_pkg::SP_RST) begin
                  next_st.pc = pcrs_pkg::PC_RST;
                  next_st.unf = 1'b1;
               end else begin
                  next_st.pc = {top_of_stack[20:1], 1'b0};
                  next_st.sp = st.sp - 5'h01;
               end
            end
            pcrs_pkg::PCRS_OP_POP: begin
               if (st.sp == pcrs_pkg::SP_RST) begin
                  next_st.unf = 1'b1;
               end else begin
                  next_st.sp = st.sp - 5'h01;
               end
               next_st.pc = st.pc + pcrs_pkg::PC_STEP;
            end
            default: begin
            end
         endcase
      end

      if (do_push) begin
         if (st.sp == pcrs_pkg::SP_MAX) begin
            next_st.full = 1'b1;
         end else begin
            next_st.sp = st.sp + 5'h01;
            next_st.stk[st.sp] = push_val;
            if (st.sp == pcrs_pkg::SP_MAX - 5'h01) begin
               next_st.full = 1'b1;
               if (st.ore) begin
                  // stores pc+2 then resets core; pointer back to empty
                  next_st.stk[st.sp] = st.pc + pcrs_pkg::PC_STEP;
                  next_st.sp = pcrs_pkg::SP_RST;
                  next_st.pc = pcrs_pkg::PC_RST;
                  next_st.core_reset = 1'b1;
               end
            end
         end
      end

      // bus side; software is expected not to race the sequencer on the stack
      if (req) begin
         next_st.wait_n = 1'b1;
         next_st.rdata = 32'h00000000;
         if (avs_read && mapped) begin
            case (word)
               pcrs_pkg::OFS_PCL: begin
                  next_st.rdata = {24'h000000, st.pc[7:0]};
                  next_st.lat_h = st.pc[15:8];
                  next_st.lat_u = st.pc[20:16];
               end
               pcrs_pkg::OFS_PC_HIGH_LATCH: next_st.rdata = {24'h000000, st.lat_h};
               pcrs_pkg::OFS_PC_UPPER_LATCH: next_st.rdata = {27'h0, st.lat_u};
               pcrs_pkg::OFS_SPR: next_st.rdata = {24'h000000, st.full, st.unf, 1'b0, st.sp};
               pcrs_pkg::OFS_TOP_OF_STACK_LOW: next_st.rdata = {24'h000000, top_of_stack[7:0]};
               pcrs_pkg::OFS_TOP_OF_STACK_HIGH: next_st.rdata = {24'h000000, top_of_stack[15:8]};
               pcrs_pkg::OFS_TOP_OF_STACK_UPPER: next_st.rdata = {27'h0, top_of_stack[20:16]};
               // no full pc view: upper pc bytes reach software only through the latches
               pcrs_pkg::OFS_CFG: next_st.rdata = {31'h0, st.ore};
               default: next_st.rdata = 32'h00000000;
            endcase
         end else if (avs_write && mapped && avs_byteenable[0]) begin
            case (word)
               pcrs_pkg::OFS_PCL: begin
                  next_st.pc = {st.lat_u, st.lat_h, avs_writedata[7:1], 1'b0};
               end
               pcrs_pkg::OFS_PC_HIGH_LATCH: next_st.lat_h = avs_writedata[7:0];
               pcrs_pkg::OFS_PC_UPPER_LATCH: next_st.lat_u = avs_writedata[4:0];
               pcrs_pkg::OFS_SPR: begin
                  next_st.sp = avs_writedata[4:0];
                  // flags clear only; a same-cycle hardware set wins
                  if (!avs_writedata[pcrs_pkg::FULL_BIT] && !(do_push && st.sp >= pcrs_pkg::SP_MAX - 5'h01)) begin
                     next_st.full = 1'b0;
                  end
                  if (!avs_writedata[pcrs_pkg::UNF_BIT] && !(cmd.valid && st.sp == pcrs_pkg::SP_RST &&
                      (cmd.op == pcrs_pkg::PCRS_OP_RETURN || cmd.op == pcrs_pkg::PCRS_OP_POP))) begin
                     next_st.unf = 1'b0;
                  end
               end
               pcrs_pkg::OFS_TOP_OF_STACK_LOW: if (st.sp != pcrs_pkg::SP_RST) next_st.stk[idx][7:0] = avs_writedata[7:0];
               pcrs_pkg::OFS_TOP_OF_STACK_HIGH: if (st.sp != pcrs_pkg::SP_RST) next_st.stk[idx][15:8] = avs_writedata[7:0];
               pcrs_pkg::OFS_TOP_OF_STACK_UPPER: if (st.sp != pcrs_pkg::SP_RST) next_st.stk[idx][20:16] = avs_writedata[4:0];
               pcrs_pkg::OFS_CFG: next_st.ore = avs_writedata[0];
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
         st.ore <= pcrs_pkg::ORE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign avs_readdata    = st.rdata;
   assign avs_waitrequest = ~st.wait_n;
   assign pc              = st.pc;
   assign overflow_reset  = st.core_reset;
endmodule
`default_nettype wire

// >>> pcrs_pkg.sv
// package for the program counter and return stack block
// assumes a single core clock and an avalon-mm register master
//
// Contract
// - 21-bit pc, only low byte software-visible
// - pc high/upper bytes loaded only via latches
// - low byte write copies latches into pc
// - low byte read copies pc into latches
// - byte addressed, lsb zero, advance by two
// - call/goto/branch load pc directly, no latches
// - 31 by 21-bit stack, 5-bit pointer
// - push: increment pointer, then store return address
// - return: load pc from top, then decrement
// - calls and returns leave latches untouched
// - reset clears pointer; zero means empty
// - three registers expose top entry bytes
// - pointer 0 to 31, software readable/writable
// - full flag after 31 pushes without pop
// - full/underflow sticky, software clear only
// - overflow reset: store pc+2, flag, reset
// - no overflow reset: pointer stays 31
// - empty pop: pc zero, underflow, pointer zero (on an empty stack the pop op advances pc by two instead; return zeroes it)
// - push instruction stores current pc
// - pop instruction only decrements pointer
// - full bit7, underflow bit6, bit5 zero
package pcrs_pkg;
   localparam int unsigned PC_W    = 21;
   localparam int unsigned SP_W    = 5;
   localparam int unsigned DEPTH   = 31;
   localparam logic [4:0]  SP_MAX  = 5'h1f;
   localparam logic [4:0]  SP_RST  = 5'h00;
   localparam logic [20:0] PC_RST  = 21'h00000;
   localparam logic [20:0] PC_STEP = 21'h00002;
   localparam logic [7:0]  BYTE_RST = 8'h00;

   // register word offsets (address bits 5:2, one word each)
   localparam logic [3:0] OFS_PCL    = 4'h0;
   localparam logic [3:0] OFS_PC_HIGH_LATCH = 4'h1;
   localparam logic [3:0] OFS_PC_UPPER_LATCH = 4'h2;
   localparam logic [3:0] OFS_SPR    = 4'h3;
   localparam logic [3:0] OFS_TOP_OF_STACK_LOW   = 4'h4;
   localparam logic [3:0] OFS_TOP_OF_STACK_HIGH   = 4'h5;
   localparam logic [3:0] OFS_TOP_OF_STACK_UPPER   = 4'h6;
   localparam logic [3:0] OFS_PCVIEW = 4'h7;
   localparam logic [3:0] OFS_CFG    = 4'h8;

   localparam int unsigned FULL_BIT = 7;
   localparam int unsigned UNF_BIT  = 6;
   localparam logic        ORE_RST  = 1'b1;

   typedef enum logic [7:0] {
      PCRS_OP_NONE   = 8'h01,
      PCRS_OP_STEP   = 8'h02,
      PCRS_OP_JUMP   = 8'h04,
      PCRS_OP_CALL   = 8'h08,
      PCRS_OP_RETURN = 8'h10,
      PCRS_OP_PUSH   = 8'h20,
      PCRS_OP_POP    = 8'h40,
      PCRS_OP_RSVD   = 8'h80
   } pcrs_op_e;

   typedef struct packed {
      logic       valid;
      pcrs_op_e   op;
      logic [20:0] target;
   } pcrs_cmd_s;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [5:0]  address;
      logic [31:0] writedata;
   } pcrs_bus_s;

   typedef struct packed {
      logic [20:0]             pc;
      logic [7:0]              lat_h;
      logic [4:0]              lat_u;
      logic [4:0]              sp;
      logic                    full;
      logic                    unf;
      logic                    ore;
      logic [DEPTH-1:0][20:0]  stk;
      logic [31:0]             rdata;
      logic                    wait_n;
      logic                    core_reset;
   } pcrs_state_s;
endpackage

// >>> pcrs_seq_model.sv
// sequencer stand-in: one registered command per bench request
// assumes req.valid is raised for a single cycle
`timescale 1ns/10ps
`default_nettype none
module pcrs_seq_model (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire pcrs_pkg::pcrs_cmd_s req,
   output var  pcrs_pkg::pcrs_cmd_s cmd
);
   // idle target toggles so a stale value is never trusted
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) cmd <= '0;
      else cmd <= req.valid ? req : '{1'b0, pcrs_pkg::PCRS_OP_NONE, ~cmd.target};
endmodule
`default_nettype wire

// >>> pcrs_core_sva.sv
// checker on the pcrs_core ports
// assumes clk and async reset_n only
`timescale 1ns/10ps
`default_nettype none
module pcrs_core_sva (
   input wire logic                clk,
   input wire logic                reset_n,
   input wire pcrs_pkg::pcrs_cmd_s cmd,
   input wire logic [5:0]          avs_address,
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic [31:0]         avs_readdata,
   input wire logic                avs_waitrequest,
   input wire logic [20:0]         pc,
   input wire logic                overflow_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // bus writes may override the sequencer
   wire logic go = cmd.valid & ~avs_write;
   wire logic rq = avs_read & avs_waitrequest;
   property p_lsb; !pc[0]; endproperty
   a_lsb: assert property (p_lsb) else $error("pc lsb set");
   property p_stp; go && cmd.op == pcrs_pkg::PCRS_OP_STEP |=> pc == $past(pc) + 21'h2; endproperty
   a_stp: assert property (p_stp) else $error("step");
   property p_jmp; go && cmd.op == pcrs_pkg::PCRS_OP_JUMP |=> pc == $past(cmd.target); endproperty
   a_jmp: assert property (p_jmp) else $error("jump");
   property p_cal; go && cmd.op == pcrs_pkg::PCRS_OP_CALL |=> overflow_reset || pc == $past(cmd.target); endproperty
   a_cal: assert property (p_cal) else $error("call");
   property p_pop; go && cmd.op == pcrs_pkg::PCRS_OP_POP |=> pc == $past(pc) + 21'h2; endproperty
   a_pop: assert property (p_pop) else $error("pop loaded pc");
   property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
   a_ans: assert property (p_ans) else $error("answer");
   property p_unm; rq && avs_address[5:2] > 4'h8 |=> avs_readdata == 32'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped");
   property p_spr; rq && avs_address[5:2] == 4'h3 |=> avs_readdata[31:8] == 24'h0 && !avs_readdata[5]; endproperty
   a_spr: assert property (p_spr) else $error("pointer bits");
   property p_ovr; overflow_reset |-> pc == 21'h0 ##1 !overflow_reset; endproperty
   a_ovr: assert property (p_ovr) else $error("overflow");
endmodule
bind pcrs_core pcrs_core_sva u_sva (.clk(clk), .reset_n(reset_n), .cmd(cmd), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pc(pc), .overflow_reset(overflow_reset));
`default_nettype wire

// >>> tb_top.sv
// bench for pcrs_core checked against an integer model
// assumes pcrs_seq_model drives cmd; byteenable is tied on
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic                clk, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, overflow_reset;
   logic [5:0]          avs_address = 6'h00;
   logic [31:0]         avs_writedata = 32'h0, avs_readdata, q;
   logic [20:0]         pc;
   pcrs_pkg::pcrs_cmd_s rq = '0, cmd;
   int                  err_total, compares, m_pc, m_sp, m_full, m_unf, m_lh, m_lu, e, m_ov, m_ore = 1;
   logic                ov;
   int                  m_stk[32];
   logic [5:0]          ad[9] = '{6'h04, 6'h08, 6'h00, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h20, 6'h24};
   pcrs_seq_model seq (.clk(clk), .reset_n(reset_n), .req(rq), .cmd(cmd));
   pcrs_core dut (.clk(clk), .reset_n(reset_n), .cmd(cmd), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pc(pc), .overflow_reset(overflow_reset));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic int exp_rd(input logic [5:0] a);
      case (a)
         6'h00: return m_pc % 256;
         6'h04: return m_lh;
         6'h08: return m_lu;
         6'h0c: return m_full * 128 + m_unf * 64 + m_sp;
         6'h10, 6'h14, 6'h18: return m_sp ? (m_stk[m_sp] >> (2 * (a - 16))) % 256 : 0;
         6'h20: return m_ore;
         default: return 0;
      endcase
   endfunction
   function automatic logic [20:0] rnd();
      return 21'($urandom) & 21'h1ffffe;
   endfunction
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= ~w;
      avs_write <= w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (!w && a == 6'h00) m_lh = m_pc / 256 % 256;
      if (!w && a == 6'h00) m_lu = m_pc / 65536;
      if (w) case (a)
         6'h00: m_pc = m_lu * 65536 + m_lh * 256 + (d & 8'hfe);
         6'h04: m_lh = d;
         6'h08: m_lu = d % 32;
         6'h10: if (m_sp) m_stk[m_sp] = m_stk[m_sp] / 256 * 256 + d;
         6'h20: m_ore = d % 2;
         6'h0c: begin
            m_sp = d % 32;
            m_full &= d[7];
            m_unf &= d[6];
         end
      endcase
      @(posedge clk);
   endtask
   task automatic rd(input logic [5:0] a);
      e = exp_rd(a);
      bus(1'b0, a, 8'h00);
      check(q, e);
   endtask
   task automatic run(input pcrs_pkg::pcrs_op_e op, input logic [20:0] t);
      rq <= '{1'b1, op, t};
      @(posedge clk);
      rq.valid <= 1'b0;
      @(posedge clk);
      // the overflow pulse stands one cycle; look mid-cycle
      @(negedge clk);
      ov = overflow_reset;
      @(posedge clk);
      m_ov = 0;
      case (op)
         pcrs_pkg::PCRS_OP_STEP: m_pc = (m_pc + 2) % 2097152;
         pcrs_pkg::PCRS_OP_JUMP: m_pc = t;
         pcrs_pkg::PCRS_OP_POP: begin
            m_unf |= m_sp == 0;
            m_sp -= m_sp > 0;
            m_pc = (m_pc + 2) % 2097152;
         end
         pcrs_pkg::PCRS_OP_RETURN: begin
            m_unf |= m_sp == 0;
            m_pc = m_sp ? m_stk[m_sp] : 0;
            m_sp -= m_sp > 0;
         end
         default: begin
            m_ov = m_sp == 30 && m_ore;
            if (m_sp < 31) m_stk[m_sp + 1] = m_ov ? (m_pc + 2) % 2097152 : m_pc;
            m_full |= m_sp >= 30;
            m_sp += m_sp < 31;
            m_pc = (op == pcrs_pkg::PCRS_OP_CALL) ? t : (m_pc + 2) % 2097152;
            if (m_ov) m_pc = 0;
            if (m_ov) m_sp = 0;
         end
      endcase
      check(pc, m_pc);
      check(ov, m_ov);
      rd(6'h0c);
   endtask
   task automatic results;
      if (err_total == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #300000;
      err_total++;
      results();
   end
   initial begin
      void'($urandom(32'h7ea2));
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      foreach (ad[k]) rd(ad[k]);
      bus(1'b1, 6'h04, 8'($urandom));
      bus(1'b1, 6'h08, 8'($urandom));
      bus(1'b1, 6'h00, 8'($urandom));
      check(pc, m_pc);
      run(pcrs_pkg::PCRS_OP_JUMP, rnd());
      run(pcrs_pkg::PCRS_OP_STEP, 21'h0);
      for (int i = 0; i < 4; i++) begin
         run(i < 3 ? pcrs_pkg::PCRS_OP_CALL : pcrs_pkg::PCRS_OP_PUSH, rnd());
         foreach (ad[k]) rd(ad[k]);
      end
      for (int i = 0; i < 5; i++) run(i ? pcrs_pkg::PCRS_OP_RETURN : pcrs_pkg::PCRS_OP_POP, 21'h0);
      bus(1'b1, 6'h10, 8'h5a);
      foreach (ad[k]) rd(ad[k]);
      bus(1'b1, 6'h0c, 8'hc0);
      rd(6'h0c);
      bus(1'b1, 6'h0c, 8'h00);
      rd(6'h0c);
      run(pcrs_pkg::PCRS_OP_CALL, rnd());
      bus(1'b1, 6'h10, 8'h3c);
      run(pcrs_pkg::PCRS_OP_RETURN, 21'h0);
      bus(1'b1, 6'h20, 8'h00);
      for (int i = 0; i < 32; i++) run(pcrs_pkg::PCRS_OP_CALL, rnd());
      rd(6'h10);
      bus(1'b1, 6'h0c, 8'h1e);
      bus(1'b1, 6'h20, 8'h01);
      run(pcrs_pkg::PCRS_OP_CALL, rnd());
      results();
   end
endmodule
`default_nettype wire
